// ==== include/dwl_regs.svh ====
`ifndef DWL_REGS_SVH
`define DWL_REGS_SVH

// mode register select codes on the link
`define DWL_MR_SEL_MR1 2'h1
`define DWL_MR_SEL_MR2 2'h2
`define DWL_ADDR_W 14

// mode register one fields
`define DWL_MR1_LVL_BIT 7
`define DWL_MR1_QOFF_BIT 12
`define DWL_MR1_RESET 14'h0000

// mode register two: dynamic write termination field, zero means disabled
`define DWL_MR2_RTTWR_LSB 9
`define DWL_MR2_RESET 14'h0000

// clocks: system clock and the link clock made by the controller divider
`define DWL_CLK_NS 25
`define DWL_CK_NS 200
`define DWL_CK_DIV (`DWL_CK_NS / `DWL_CLK_NS)

// link timing, in link clock periods (nCK)
`define DWL_T_MOD_NCK 24
`define DWL_T_MRD_NCK 8
`define DWL_DODTLON_NCK 10
`define DWL_T_ADC_NCK 2
`define DWL_T_WLDQSEN_NCK 40
`define DWL_T_DQSL_NCK 1
`define DWL_T_WLMRD_NCK 40
`define DWL_T_FB_NCK 4
`define DWL_T_ODTOFF_NCK 12

// controller register offsets and fields
`define DWL_REG_CTRL 8'h00
`define DWL_REG_STATUS 8'h04
`define DWL_REG_DELAY 8'h08
`define DWL_CTRL_START 0
`define DWL_CTRL_LAT 1
`define DWL_ST_BUSY 0
`define DWL_ST_DONE 1
`define DWL_ST_FAIL 2
`define DWL_ST_LOCK_LSB 4
`define DWL_ST_FB_LSB 8

`endif

// ==== include/dwl_pkg.sv ====
package dwl_pkg;

    typedef enum logic [3:0] {
        DWL_C_IDLE = 4'h0,
        DWL_C_RTTWR = 4'h1,
        DWL_C_QOFF = 4'h2,
        DWL_C_ENTRY = 4'h3,
        DWL_C_ODT = 4'h4,
        DWL_C_DQSEN = 4'h5,
        DWL_C_PULSE = 4'h6,
        DWL_C_FB = 4'h7,
        DWL_C_STEP = 4'h8,
        DWL_C_RELEASE = 4'h9,
        DWL_C_ODTOFF = 4'hA,
        DWL_C_EXIT = 4'hB,
        DWL_C_RESTORE = 4'hC,
        DWL_C_DONE = 4'hD
    } dwl_cstate_t;

endpackage

// ==== include/dwl_if.sv ====
`timescale 1ns/1ps
interface dwl_if #(
    parameter int LANES = 2,
    parameter int RANKS = 1
);
    logic ck;
    logic [RANKS-1:0] cs_n;
    logic mrs;
    logic [1:0] mr_sel;
    logic [13:0] addr;
    logic odt;
    logic [LANES-1:0] dqs_t;
    logic [LANES-1:0] dqs_c;
    logic [LANES-1:0] dqs_oe;
    logic [LANES-1:0] dqs_t_line;
    logic [8*LANES-1:0] dq;
    logic dq_oe;
    logic [8*LANES-1:0] dq_line;

    // undriven lines settle low through termination
    assign dqs_t_line = dqs_t & dqs_oe;
    assign dq_line = dq_oe ? dq : '0;

    modport ctrl (
        output ck, cs_n, mrs, mr_sel, addr, odt, dqs_t, dqs_c, dqs_oe,
        input dq_line
    );
    modport dev (
        input ck, cs_n, mrs, mr_sel, addr, odt, dqs_t_line,
        output dq, dq_oe
    );
endinterface

// ==== hw/dwl_sync.sv ====
`timescale 1ns/1ps
module dwl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== hw/dwl_dev.sv ====
`timescale 1ns/1ps
`include "dwl_regs.svh"
module dwl_dev
    import dwl_pkg::*;
#(
    parameter int LANES = 2,
    parameter int RANKS = 1,
    parameter int RANK = 0
) (
    // system
    input wire logic clk_sys,
    input wire logic rstn,
    // memory link
    dwl_if.dev link,
    // status
    output logic lvl_mode,
    output logic out_disable,
    output logic [13:0] mr1,
    output logic fb_valid,
    output logic term_dqs_on,
    output logic term_dqs_nominal,
    output logic term_dq_on
);
    localparam int SW = 20 + LANES;

    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic ck_s;
    logic cs_n_s;
    logic mrs_s;
    logic [1:0] sel_s;
    logic [13:0] addr_s;
    logic odt_s;
    logic [LANES-1:0] dqs_s;
    logic ck_d;
    logic [LANES-1:0] dqs_d;
    logic [LANES-1:0] fb;
    logic lvl_d;
    logic [7:0] mod_cnt;
    logic ck_rise;

    assign raw = {link.ck, link.cs_n[RANK], link.mrs, link.mr_sel, link.addr,
                  link.odt, link.dqs_t_line};

    dwl_sync #(.W(SW)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(raw),
        .q(syn)
    );

    // all link inputs share one latency, so strobe-to-clock phase survives
    assign {ck_s, cs_n_s, mrs_s, sel_s, addr_s, odt_s, dqs_s} = syn;
    assign ck_rise = ck_s & ~ck_d;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ck_d <= 1'b0;
            dqs_d <= '0;
            lvl_d <= 1'b0;
        end else begin
            ck_d <= ck_s;
            dqs_d <= dqs_s;
            lvl_d <= lvl_mode;
        end
    end

    // mode register one: every field of a write is applied, exit included
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mr1 <= `DWL_MR1_RESET;
        end else if (ck_rise && !cs_n_s && mrs_s && sel_s == `DWL_MR_SEL_MR1) begin
            mr1 <= addr_s;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lvl_mode <= 1'b0;
            out_disable <= 1'b0;
        end else begin
            lvl_mode <= mr1[`DWL_MR1_LVL_BIT];
            out_disable <= mr1[`DWL_MR1_QOFF_BIT];
        end
    end

    // clock level caught on each strobe rise, per byte lane, held until exit
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                fb[l] <= 1'b0;
            end else if (!lvl_mode) begin
                fb[l] <= 1'b0;
            end else if (dqs_s[l] && !dqs_d[l]) begin
                fb[l] <= ck_s;
            end
        end
    end

    // feedback is meaningless from entry until the first strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fb_valid <= 1'b0;
        end else if (!lvl_mode) begin
            fb_valid <= 1'b0;
        end else if (|(dqs_s & ~dqs_d)) begin
            fb_valid <= 1'b1;
        end
    end

    // data pins stay in undefined drive for tMOD after the exit write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mod_cnt <= 8'h00;
        end else if (lvl_d && !lvl_mode) begin
            mod_cnt <= 8'(`DWL_T_MOD_NCK);
        end else if (ck_rise && mod_cnt != 8'h00) begin
            mod_cnt <= mod_cnt - 8'h01;
        end
    end

    // no read strobe is ever driven back; feedback rides the data pins only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            link.dq <= '0;
            link.dq_oe <= 1'b0;
        end else begin
            link.dq_oe <= (lvl_mode || mod_cnt != 8'h00) && !out_disable;
            for (int l = 0; l < LANES; l++) begin
                link.dq[8*l +: 8] <= {8{fb[l] & fb_valid}};
            end
        end
    end

    // in leveling the termination pin only moves the strobe resistor
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            term_dqs_on <= 1'b0;
            term_dqs_nominal <= 1'b0;
            term_dq_on <= 1'b0;
        end else begin
            term_dqs_on <= lvl_mode;
            term_dqs_nominal <= lvl_mode & odt_s;
            term_dq_on <= ~lvl_mode & odt_s;
        end
    end
endmodule

// ==== hw/dwl_ctrl.sv ====
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dwl_regs.svh"
module dwl_ctrl
    import dwl_pkg::*;
#(
    parameter int LANES = 2,
    parameter int RANKS = 1,
    parameter int TARGET = 0,
    parameter int CK_DIV = `DWL_CK_DIV
) (
    // system
    input wire logic clk_sys,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory link
    dwl_if.ctrl link
);
    localparam int DW = $clog2(CK_DIV);
    localparam logic [DW-1:0] LAST = DW'(CK_DIV - 1);
    localparam logic [DW-1:0] FALL = DW'(CK_DIV / 2 - 1);
    localparam logic [DW-1:0] HALF = DW'(CK_DIV / 2);
    localparam logic [DW+1:0] MAX_STEPS = (DW+2)'(2 * CK_DIV);
    localparam logic [RANKS-1:0] TGT = RANKS'(1) << TARGET;
    localparam logic [13:0] QOFF_SET = 14'(1) << `DWL_MR1_QOFF_BIT;
    localparam logic [13:0] LVL_SET = 14'(1) << `DWL_MR1_LVL_BIT;

    dwl_cstate_t state;
    logic [DW-1:0] ck_cnt;
    logic slot;
    logic [7:0] wait_cnt;
    logic [7:0] en_cnt;
    logic start;
    logic lat_raised;
    logic done;
    logic fail;
    logic pulse_arm;
    logic [LANES-1:0] pdone;
    logic [LANES-1:0] locked;
    logic [LANES-1:0] prev_fb;
    logic [LANES-1:0] fb;
    logic [DW+1:0] steps;
    logic [LANES-1:0][DW-1:0] dly;
    logic [LANES-1:0][DW-1:0] dly_init;
    logic [8*LANES-1:0] dq_s;
    logic [31:0] status_word;
    logic [31:0] delay_word;
    logic apb_setup;
    logic apb_wr;

    function automatic logic lane_fb(input logic [8*LANES-1:0] d, input int l);
        return &d[8*l +: 8];
    endfunction

    // returned data is terminated on this side of the link
    dwl_sync #(.W(8*LANES)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d(link.dq_line),
        .q(dq_s)
    );

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            fb[l] = lane_fb(dq_s, l);
        end
    end

    // link clock divider; commands change on the falling half
    assign slot = (ck_cnt == FALL);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ck_cnt <= '0;
        end else begin
            ck_cnt <= (ck_cnt == LAST) ? '0 : ck_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            link.ck <= 1'b0;
        end else if (ck_cnt == LAST) begin
            link.ck <= 1'b1;
        end else if (slot) begin
            link.ck <= 1'b0;
        end
    end

    // apb: no wait state, answer registered
    assign apb_setup = psel & ~penable & ~pready;
    assign apb_wr = psel & penable & pready & pwrite;

    always_comb begin
        status_word = '0;
        delay_word = '0;
        status_word[`DWL_ST_BUSY] = (state != DWL_C_IDLE);
        status_word[`DWL_ST_DONE] = done;
        status_word[`DWL_ST_FAIL] = fail;
        status_word[`DWL_ST_LOCK_LSB +: LANES] = locked;
        status_word[`DWL_ST_FB_LSB +: LANES] = fb;
        for (int l = 0; l < LANES; l++) begin
            delay_word[8*l +: DW] = dly[l];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            if (apb_setup) begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
                case (paddr)
                    `DWL_REG_CTRL: prdata[`DWL_CTRL_LAT] <= lat_raised;
                    `DWL_REG_STATUS: prdata <= status_word;
                    `DWL_REG_DELAY: prdata <= delay_word;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            start <= 1'b0;
            lat_raised <= 1'b0;
            dly_init <= '0;
        end else begin
            start <= apb_wr && paddr == `DWL_REG_CTRL && pwdata[`DWL_CTRL_START];
            if (apb_wr && paddr == `DWL_REG_CTRL) begin
                lat_raised <= pwdata[`DWL_CTRL_LAT];
            end
            if (apb_wr && paddr == `DWL_REG_DELAY) begin
                for (int l = 0; l < LANES; l++) begin
                    dly_init[l] <= pwdata[8*l +: DW];
                end
            end
        end
    end

    // one strobe rise per lane per pulse, at its own phase after the clock rise
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                link.dqs_t[l] <= 1'b0;
                link.dqs_c[l] <= 1'b1;
                pdone[l] <= 1'b0;
            end else if (!pulse_arm) begin
                link.dqs_t[l] <= 1'b0;
                link.dqs_c[l] <= 1'b1;
                pdone[l] <= 1'b0;
            end else if (!pdone[l] && ck_cnt == dly[l]) begin
                link.dqs_t[l] <= 1'b1;
                link.dqs_c[l] <= 1'b0;
                pdone[l] <= 1'b1;
            end else if (link.dqs_t[l] && ck_cnt == dly[l] + HALF) begin
                link.dqs_t[l] <= 1'b0;
                link.dqs_c[l] <= 1'b1;
            end
        end
    end

    // sequence; every slot without an action carries a deselect
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= DWL_C_IDLE;
            wait_cnt <= 8'h00;
            en_cnt <= 8'h00;
            link.cs_n <= '1;
            link.mrs <= 1'b0;
            link.mr_sel <= `DWL_MR_SEL_MR1;
            link.addr <= `DWL_MR1_RESET;
            link.odt <= 1'b0;
            link.dqs_oe <= '0;
            pulse_arm <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            locked <= '0;
            prev_fb <= '1;
            steps <= '0;
            dly <= '0;
        end else if (start && state == DWL_C_IDLE) begin
            state <= DWL_C_RTTWR;
            done <= 1'b0;
            fail <= 1'b0;
            locked <= '0;
            prev_fb <= '1;
            steps <= '0;
            dly <= dly_init;
        end else if (slot) begin
            link.cs_n <= '1;
            link.mrs <= 1'b0;
            if (en_cnt != 8'h00) begin
                en_cnt <= en_cnt - 8'h01;
            end
            if (wait_cnt != 8'h00) begin
                wait_cnt <= wait_cnt - 8'h01;
            end else begin
                case (state)
                    DWL_C_IDLE: state <= DWL_C_IDLE;
                    DWL_C_RTTWR: begin
                        link.cs_n <= '0;
                        link.mrs <= 1'b1;
                        link.mr_sel <= `DWL_MR_SEL_MR2;
                        link.addr <= `DWL_MR2_RESET;
                        wait_cnt <= 8'(`DWL_T_MRD_NCK - 1);
                        state <= DWL_C_QOFF;
                    end
                    DWL_C_QOFF: begin
                        if (RANKS > 1) begin
                            link.cs_n <= TGT;
                            link.mrs <= 1'b1;
                            link.mr_sel <= `DWL_MR_SEL_MR1;
                            link.addr <= QOFF_SET;
                            wait_cnt <= 8'(`DWL_T_MRD_NCK - 1);
                        end
                        state <= DWL_C_ENTRY;
                    end
                    DWL_C_ENTRY: begin
                        link.cs_n <= ~TGT;
                        link.mrs <= 1'b1;
                        link.mr_sel <= `DWL_MR_SEL_MR1;
                        link.addr <= LVL_SET;
                        wait_cnt <= lat_raised ? 8'(`DWL_T_MOD_NCK + `DWL_DODTLON_NCK - 1)
                                               : 8'(`DWL_T_MOD_NCK - 1);
                        en_cnt <= 8'(`DWL_T_WLDQSEN_NCK - 1);
                        state <= DWL_C_ODT;
                    end
                    DWL_C_ODT: begin
                        link.odt <= 1'b1;
                        state <= DWL_C_DQSEN;
                    end
                    DWL_C_DQSEN: begin
                        if (en_cnt == 8'h00) begin
                            link.dqs_oe <= '1;
                            wait_cnt <= 8'(`DWL_T_WLMRD_NCK - 1);
                            state <= DWL_C_PULSE;
                        end
                    end
                    DWL_C_PULSE: begin
                        pulse_arm <= 1'b1;
                        wait_cnt <= 8'(`DWL_T_FB_NCK - 1);
                        state <= DWL_C_FB;
                    end
                    DWL_C_FB: begin
                        pulse_arm <= 1'b0;
                        prev_fb <= fb;
                        steps <= steps + 1'b1;
                        for (int l = 0; l < LANES; l++) begin
                            if (!locked[l] && !prev_fb[l] && fb[l]) begin
                                locked[l] <= 1'b1;
                            end else if (!locked[l]) begin
                                dly[l] <= dly[l] + 1'b1;
                            end
                        end
                        state <= DWL_C_STEP;
                    end
                    DWL_C_STEP: begin
                        if (&locked) begin
                            state <= DWL_C_RELEASE;
                        end else if (steps >= MAX_STEPS) begin
                            fail <= 1'b1;
                            state <= DWL_C_RELEASE;
                        end else begin
                            state <= DWL_C_PULSE;
                        end
                    end
                    DWL_C_RELEASE: begin
                        link.dqs_oe <= '0;
                        state <= DWL_C_ODTOFF;
                    end
                    DWL_C_ODTOFF: begin
                        link.odt <= 1'b0;
                        wait_cnt <= 8'(`DWL_T_ODTOFF_NCK - 1);
                        state <= DWL_C_EXIT;
                    end
                    DWL_C_EXIT: begin
                        link.cs_n <= ~TGT;
                        link.mrs <= 1'b1;
                        link.mr_sel <= `DWL_MR_SEL_MR1;
                        link.addr <= `DWL_MR1_RESET;
                        wait_cnt <= 8'(`DWL_T_MRD_NCK - 1);
                        state <= DWL_C_RESTORE;
                    end
                    DWL_C_RESTORE: begin
                        if (RANKS > 1) begin
                            link.cs_n <= TGT;
                            link.mrs <= 1'b1;
                            link.mr_sel <= `DWL_MR_SEL_MR1;
                            link.addr <= `DWL_MR1_RESET;
                        end
                        wait_cnt <= 8'(`DWL_T_MOD_NCK - 1);
                        state <= DWL_C_DONE;
                    end
                    DWL_C_DONE: begin
                        done <= 1'b1;
                        state <= DWL_C_IDLE;
                    end
                    default: state <= DWL_C_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== verification/dwl_assertions.sv ====
`timescale 1ns/1ps
module dwl_checker #(
    parameter int LANES = 2,
    parameter int RANKS = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // link
    input wire logic ck,
    input wire logic [RANKS-1:0] cs_n,
    input wire logic mrs,
    input wire logic [1:0] mr_sel,
    input wire logic [13:0] addr,
    input wire logic odt,
    input wire logic [LANES-1:0] dqs_t,
    input wire logic [LANES-1:0] dqs_c,
    input wire logic [LANES-1:0] dqs_oe,
    input wire logic [8*LANES-1:0] dq,
    input wire logic dq_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    ck_shape_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
        else $error("link clock high phase wrong");
    cmd_width_a: assert property ($fell(cs_n[0]) |-> !cs_n[0] [*8] ##1 cs_n[0])
        else $error("command not one link period");
    quiet_odt_a: assert property (mrs && !cs_n[0] |-> !odt)
        else $error("mode write while termination pin high");
    rttwr_off_a: assert property (mrs && !cs_n[0] && mr_sel == 2'h2
        |-> addr[11:9] == 3'h0)
        else $error("dynamic termination not disabled");
    strobe_pair_a: assert property (dqs_oe[0] |-> dqs_c[0] == !dqs_t[0])
        else $error("strobe pair not complementary");
    strobe_term_a: assert property (|dqs_oe |-> odt)
        else $error("strobe driven without termination pin");
    pulse_width_a: assert property ($rose(dqs_t[0])
        |-> (dqs_t[0] && dqs_oe[0]) [*4] ##1 !dqs_t[0])
        else $error("strobe pulse malformed");
    fb_lane_a: assert property (dq_oe
        |-> (dq[7:0] inside {8'h00, 8'hFF}) && (dq[15:8] inside {8'h00, 8'hFF}))
        else $error("lane bits disagree");
    odt_lead_a: assert property ($rose(dqs_oe[0]) |-> $past(odt, 16))
        else $error("strobe enabled too soon after termination pin");
    exit_after_a: assert property ($fell(odt) |-> ##[1:120] (mrs && !cs_n[0] && !addr[7]))
        else $error("no exit write after termination off");

    cover property ($rose(dqs_t[0]));
    cover property (mrs && !cs_n[0] && addr[7]);
    cover property (dq_oe && dq[7:0] == 8'hFF);
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lvl_mode;
    logic out_disable;
    logic [13:0] mr1;
    logic t_on;
    logic t_nom;
    logic t_dq;
    logic fbv;
    logic [31:0] seed = 32'h000040B1;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;
    logic [31:0] dly;
    logic [1:0] last_dqs = 2'b00;
    logic [1:0] ck_at = 2'b00;
    logic [1:0] have_fb = 2'b00;

    always #12.5 clk_sys = ~clk_sys;

    dwl_if #(.LANES(2), .RANKS(1)) dwl_if_i ();
    dwl_ctrl dwl_ctrl_i (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(dwl_if_i.ctrl));
    dwl_dev dwl_dev_i (.clk_sys(clk_sys), .rstn(rstn),
        .link(dwl_if_i.dev), .lvl_mode(lvl_mode), .out_disable(out_disable), .mr1(mr1),
        .fb_valid(fbv), .term_dqs_on(t_on), .term_dqs_nominal(t_nom), .term_dq_on(t_dq));
    dwl_checker dwl_checker_i (.clk_sys(clk_sys), .rstn(rstn),
        .ck(dwl_if_i.ck), .cs_n(dwl_if_i.cs_n), .mrs(dwl_if_i.mrs), .mr_sel(dwl_if_i.mr_sel),
        .addr(dwl_if_i.addr), .odt(dwl_if_i.odt), .dqs_t(dwl_if_i.dqs_t),
        .dqs_c(dwl_if_i.dqs_c), .dqs_oe(dwl_if_i.dqs_oe), .dq(dwl_if_i.dq),
        .dq_oe(dwl_if_i.dq_oe));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] exp_fb(input logic level);
        return {8{level}};
    endfunction

    // lock lands where the strobe rises in the first high clock phase
    function automatic logic [31:0] exp_lock();
        return 32'h00000707;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        print_verdict();
    endtask

    // entered just after a rising edge; request held until pready seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // feedback must reflect the link clock seen at the previous strobe rise
    always @(posedge clk_sys) begin
        for (int l = 0; l < 2; l++) begin
            if (dwl_if_i.dqs_t_line[l] === 1'b1 && last_dqs[l] === 1'b0) begin
                if (have_fb[l] && dwl_if_i.dq_oe === 1'b1) begin
                    chk({23'h0, fbv, dwl_if_i.dq_line[8*l +: 8]},
                        {23'h0, 1'b1, exp_fb(ck_at[l])});
                end
                ck_at[l] <= dwl_if_i.ck;
                have_fb[l] <= 1'b1;
            end
        end
        if (lvl_mode !== 1'b1) begin
            have_fb <= 2'b00;
        end
        last_dqs <= dwl_if_i.dqs_t_line;
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h10, rnd());
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err} | rd, 32'h1);
        for (int i = 0; i < 2; i++) begin
            dly = rnd() & 32'h00000707;
            apb(1'b1, 8'h08, dly);
            // read shows the live phase; the written one applies at start
            apb(1'b0, 8'h08, 32'h0);
            chk(rd & 32'h00000707, (i == 0) ? 32'h0 : exp_lock());
            apb(1'b1, 8'h00, {30'h0, i[0], 1'b1});
            apb(1'b0, 8'h08, 32'h0);
            chk(rd & 32'h00000707, dly);
            // second start lands while busy and must be dropped
            apb(1'b1, 8'h00, {30'h0, i[0], 1'b1});
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {30'h0, i[0], 1'b0});
            for (int n = 0; n <= 4000 && dwl_if_i.dqs_oe[0] !== 1'b1; n++) begin
                @(posedge clk_sys);
                if (n == 4000) hang();
            end
            chk({27'h0, fbv, lvl_mode, t_on, t_nom, t_dq}, 32'hE);
            rd = 32'h0;
            for (int n = 0; n <= 200 && rd[1] !== 1'b1; n++) begin
                repeat (40) @(posedge clk_sys);
                apb(1'b0, 8'h04, 32'h0);
                if (n == 200) hang();
            end
            chk(rd & 32'h37, 32'h32);
            apb(1'b0, 8'h08, 32'h0);
            chk(rd & 32'h00000707, exp_lock());
            chk({27'h0, dwl_if_i.dq_oe, lvl_mode, out_disable, t_dq, mr1[7]}, 32'h0);
            repeat (200) @(posedge clk_sys);
            apb(1'b0, 8'h04, 32'h0);
            chk(rd & 32'h1, 32'h0);
        end
        print_verdict();
    end
endmodule
